/* File: hdl/adcsc_pkg.sv */
// constants, register map and types for the conversion timing control block
package adcsc_pkg;

   // register byte offsets on the apb bus
   localparam logic [7:0] CTRL_OFFS    = 8'h00;
   localparam logic [7:0] TIMING_OFFS  = 8'h04;
   localparam logic [7:0] STATUS_OFFS  = 8'h08;

   // adc_timing_control field positions
   localparam int SAMPLE_SEL_MSB = 7;
   localparam int SAMPLE_SEL_LSB = 5;
   localparam int PRESCALE_MSB   = 4;
   localparam int PRESCALE_LSB   = 0;

   // control register field positions
   localparam int HALT_MSB  = 1;
   localparam int HALT_LSB  = 0;
   localparam int START_BIT = 7;

   // status register field positions
   localparam int STS_STATE_LSB = 0;
   localparam int STS_BUSY_BIT  = 2;
   localparam int STS_HALT_BIT  = 3;
   localparam int STS_IDX_LSB   = 4;

   // values after reset
   localparam logic [7:0] TIMING_RST = 8'h05;
   localparam logic [1:0] HALT_RST   = 2'h0;

   // debug_halt_behaviour codes
   localparam logic [1:0] HALT_CONTINUE = 2'h0;
   localparam logic [1:0] HALT_RESERVED = 2'h1;
   localparam logic [1:0] HALT_FINISH   = 2'h2;
   localparam logic [1:0] HALT_NOW      = 2'h3;

   // conversion length in conversion clock cycles, and number of conversions per sequence
   localparam logic [4:0] CONV_CYCLES = 5'h0a;
   localparam logic [2:0] SEQ_LEN     = 3'h4;

   typedef enum logic [1:0]
   {
      ST_IDLE    = 2'b00,
      ST_SAMPLE  = 2'b01,
      ST_CONVERT = 2'b10,
      ST_HOLD    = 2'b11
   } adcsc_state_type;

   // sample phase length for each sample_length_select code
   function automatic logic [4:0] sample_len(input logic [2:0] sel);
      logic [4:0] len;
      len = 5'h04;
      unique case (sel)
         3'h0: len = 5'h04;
         3'h1: len = 5'h06;
         3'h2: len = 5'h08;
         3'h3: len = 5'h0a;
         3'h4: len = 5'h0c;
         3'h5: len = 5'h10;
         3'h6: len = 5'h14;
         3'h7: len = 5'h18;
      endcase
      return len;
   endfunction

endpackage

/* File: hdl/adcsc_clk_div.sv */
// conversion clock prescaler producing a one-cycle enable pulse
`timescale 1ns/1ns
module adcsc_clk_div
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // control
   input  wire logic [4:0] prescale,
   input  wire logic       restart,
   // enable pulse at conversion_clock_freq
   output logic            tick
);

   typedef struct packed
   {
      logic [5:0] cnt;
      logic       tick;
   } adcsc_div_type;

   adcsc_div_type st_r;
   adcsc_div_type st_nxt;

   // period is 2*(prescale+1) bus cycles; terminal count is {prescale,1}
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (restart)
      begin
         st_nxt.cnt = 6'h00;
      end
      else if (st_r.cnt == {prescale, 1'b1}) // R4
      begin
         st_nxt.cnt  = 6'h00;
         st_nxt.tick = 1'b1;
      end
      else
      begin
         st_nxt.cnt = st_r.cnt + 6'h01;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign tick = st_r.tick;

   // helper: bus cycles since the previous pulse
   logic [6:0] gap_r;
   logic       gap_ok_r;
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         gap_r    <= 7'h00;
         gap_ok_r <= 1'b0;
      end
      else if (restart)
      begin
         gap_r    <= 7'h00;
         gap_ok_r <= 1'b0;
      end
      else if (st_r.tick)
      begin
         gap_r    <= 7'h01;
         gap_ok_r <= 1'b1;
      end
      else
      begin
         gap_r <= gap_r + 7'h01;
      end
   end

   property p_tick_period;
      @(posedge ref_clk) disable iff (rst)
      (tick && gap_ok_r && !restart) |-> (gap_r == {1'b0, prescale, 1'b1} + 7'h01);
   endproperty
   a_tick_period: assert property (p_tick_period) // R4
      else $error("conversion clock period differs from 2*(prescale+1)");

endmodule // adcsc_clk_div

/* File: hdl/adcsc_top.sv */
// adc sample clock control: apb registers, prescaler, sample/convert sequencer
// Behaviour
// R1 - any write to the timing register aborts the running conversion sequence.
// R2 - bits 7 to 5 of the timing register select the sample phase length in conversion clocks.
// R3 - select codes 0 to 7 give 4, 6, 8, 10, 12, 16, 20 and 24 conversion clock cycles.
// R4 - bits 4 to 0 are the prescale value; conversion clock is bus clock over 2*(value+1).
// R5 - on debug freeze, code 10 finishes the conversion then halts, 11 halts at once, 01 reserved.
// R6 - with code 00 conversions continue normally during a debug freeze.
`timescale 1ns/1ns
module adcsc_top
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // debug freeze request from the on-chip debugger
   input  wire logic        debug_freeze,
   // sequencer status
   output logic             sample_active,
   output logic             convert_active,
   output logic             conversion_done,
   output logic             seq_busy,
   output logic             frozen,
   output logic             conv_clk_tick
);

   typedef struct packed
   {
      logic [7:0]                 timing;
      logic [1:0]                 halt;
      adcsc_pkg::adcsc_state_type state;
      logic [4:0]                 phase;
      logic [2:0]                 idx;
      logic [31:0]                rdata;
      logic                       slverr;
      logic                       done;
   } adcsc_top_type;

   adcsc_top_type st_r;
   adcsc_top_type st_nxt;

   logic tick;
   logic setup;
   logic wr_acc;
   logic wr_timing;
   logic wr_ctrl;
   logic halt_now;
   logic halt_finish;
   logic advance;
   logic busy;
   logic [4:0] sample_cycles;

   // bus phase decode; writes land in the access phase
   assign setup     = psel && !penable;
   assign wr_acc    = psel && penable && pwrite;
   assign wr_timing = wr_acc && (paddr == adcsc_pkg::TIMING_OFFS);
   assign wr_ctrl   = wr_acc && (paddr == adcsc_pkg::CTRL_OFFS);

   // reserved code 01 is treated like 00 so a misprogram cannot hang the sequencer
   assign busy       = (st_r.state != adcsc_pkg::ST_IDLE);
   assign halt_now      = debug_freeze && (st_r.halt == adcsc_pkg::HALT_NOW); // R5
   assign halt_finish   = debug_freeze && (st_r.halt == adcsc_pkg::HALT_FINISH);
   assign advance       = tick && !halt_now; // R5
   assign sample_cycles = adcsc_pkg::sample_len(
                          st_r.timing[adcsc_pkg::SAMPLE_SEL_MSB:adcsc_pkg::SAMPLE_SEL_LSB]); // R2

   adcsc_clk_div u_div
   (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .prescale (st_r.timing[adcsc_pkg::PRESCALE_MSB:adcsc_pkg::PRESCALE_LSB]),
      .restart  (wr_timing),
      .tick     (tick)
   );

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;

      // read data captured in setup so prdata comes from a flop
      if (setup)
      begin
         st_nxt.rdata  = 32'h0000_0000;
         st_nxt.slverr = 1'b0;
         unique case (paddr)
            adcsc_pkg::CTRL_OFFS:
               st_nxt.rdata[adcsc_pkg::HALT_MSB:adcsc_pkg::HALT_LSB] = st_r.halt;
            adcsc_pkg::TIMING_OFFS:
               st_nxt.rdata[7:0] = st_r.timing;
            adcsc_pkg::STATUS_OFFS:
            begin
               st_nxt.rdata[adcsc_pkg::STS_STATE_LSB +: 2] = st_r.state;
               st_nxt.rdata[adcsc_pkg::STS_BUSY_BIT]       = busy;
               st_nxt.rdata[adcsc_pkg::STS_HALT_BIT]       = frozen;
               st_nxt.rdata[adcsc_pkg::STS_IDX_LSB +: 3]   = st_r.idx;
            end
            default:
               st_nxt.slverr = 1'b1;
         endcase
      end

      // sample / convert sequencer, stepped by the conversion clock enable
      unique case (st_r.state)
         adcsc_pkg::ST_IDLE:
            st_nxt.phase = 5'h00;
         adcsc_pkg::ST_SAMPLE:
            if (advance)
            begin
               if (st_r.phase == sample_cycles - 5'h01) // R3
               begin
                  st_nxt.phase = 5'h00;
                  st_nxt.state = adcsc_pkg::ST_CONVERT;
               end
               else
                  st_nxt.phase = st_r.phase + 5'h01;
            end
         adcsc_pkg::ST_CONVERT:
            if (advance)
            begin
               if (st_r.phase == adcsc_pkg::CONV_CYCLES - 5'h01)
               begin
                  st_nxt.phase = 5'h00;
                  st_nxt.done  = 1'b1;
                  if (st_r.idx == adcsc_pkg::SEQ_LEN - 3'h1)
                  begin
                     st_nxt.idx   = 3'h0;
                     st_nxt.state = adcsc_pkg::ST_IDLE;
                  end
                  else
                  begin
                     st_nxt.idx   = st_r.idx + 3'h1;
                     // park between conversions when asked to finish then halt
                     st_nxt.state = halt_finish ? adcsc_pkg::ST_HOLD
                                               : adcsc_pkg::ST_SAMPLE; // R5
                  end
               end
               else
                  st_nxt.phase = st_r.phase + 5'h01;
            end
         adcsc_pkg::ST_HOLD:
            // a switch to code 11 while parked must keep the sequencer halted
            if (!halt_finish && !halt_now) // R5
               st_nxt.state = adcsc_pkg::ST_SAMPLE;
      endcase

      // control write: halt behaviour and sequence start
      if (wr_ctrl)
      begin
         st_nxt.halt = pwdata[adcsc_pkg::HALT_MSB:adcsc_pkg::HALT_LSB];
         if (pwdata[adcsc_pkg::START_BIT] && !busy)
         begin
            st_nxt.state = adcsc_pkg::ST_SAMPLE;
            st_nxt.phase = 5'h00;
            st_nxt.idx   = 3'h0;
         end
      end

      // timing write comes last so the abort wins over any sequencer step
      if (wr_timing)
      begin
         st_nxt.timing = pwdata[7:0];
         st_nxt.state  = adcsc_pkg::ST_IDLE; // R1
         st_nxt.phase  = 5'h00;
         st_nxt.idx    = 3'h0;
         st_nxt.done   = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st_r        <= '0;
         st_r.timing <= adcsc_pkg::TIMING_RST;
         st_r.halt   <= adcsc_pkg::HALT_RST;
         st_r.state  <= adcsc_pkg::ST_IDLE;
      end
      else
         st_r <= st_nxt;
   end

   // outputs; zero wait states, so pready may stay combinational
   assign prdata          = st_r.rdata;
   assign pslverr         = st_r.slverr && psel && penable;
   assign pready          = 1'b1;
   assign sample_active   = (st_r.state == adcsc_pkg::ST_SAMPLE);
   assign convert_active  = (st_r.state == adcsc_pkg::ST_CONVERT);
   assign conversion_done = st_r.done;
   assign seq_busy        = busy;
   assign frozen          = (halt_now && busy) || (st_r.state == adcsc_pkg::ST_HOLD);
   assign conv_clk_tick   = tick;

   // helper: conversion clocks spent in the sample phase
   logic [4:0] sample_ticks_r;
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         sample_ticks_r <= 5'h00;
      else if (st_r.state != adcsc_pkg::ST_SAMPLE)
         sample_ticks_r <= 5'h00;
      else if (advance)
         sample_ticks_r <= sample_ticks_r + 5'h01;
   end

   property p_abort_on_timing_write;
      @(posedge ref_clk) disable iff (rst)
      wr_timing |=> (st_r.state == adcsc_pkg::ST_IDLE) && !conversion_done;
   endproperty
   a_abort_on_timing_write: assert property (p_abort_on_timing_write) // R1
      else $error("timing write did not abort the sequence");

   property p_timing_readback;
      @(posedge ref_clk) disable iff (rst)
      wr_timing ##2 (setup && !pwrite && paddr == adcsc_pkg::TIMING_OFFS)
      |=> prdata[7:0] == $past(pwdata[7:0], 3);
   endproperty
   a_timing_readback: assert property (p_timing_readback) // R2
      else $error("timing register does not hold the written value");

   property p_sample_length;
      @(posedge ref_clk) disable iff (rst)
      (st_r.state == adcsc_pkg::ST_CONVERT && $past(st_r.state) == adcsc_pkg::ST_SAMPLE
       && !$past(wr_timing))
      |-> ($past(sample_ticks_r) + 5'h01 == sample_cycles);
   endproperty
   a_sample_length: assert property (p_sample_length) // R3
      else $error("sample phase length does not match the select code");

   property p_freeze_now_holds;
      @(posedge ref_clk) disable iff (rst)
      (halt_now && busy && !wr_acc) |=> $stable(st_r.phase) && $stable(st_r.state);
   endproperty
   a_freeze_now_holds: assert property (p_freeze_now_holds) // R5
      else $error("sequencer moved during an immediate freeze");

   property p_finish_then_halt;
      @(posedge ref_clk) disable iff (rst)
      (conversion_done && $past(halt_finish) && busy && !$past(wr_acc))
      |-> (st_r.state == adcsc_pkg::ST_HOLD) && frozen;
   endproperty
   a_finish_then_halt: assert property (p_finish_then_halt) // R5
      else $error("conversion did not halt after finishing under freeze");

   property p_continue_in_freeze;
      @(posedge ref_clk) disable iff (rst)
      (debug_freeze && st_r.halt == adcsc_pkg::HALT_CONTINUE) |-> !frozen && (advance == tick);
   endproperty
   a_continue_in_freeze: assert property (p_continue_in_freeze) // R6
      else $error("sequencer halted with continue code");

endmodule // adcsc_top

/* File: tb/tb.sv */
// self-checking testbench for the adc sample clock control block
`timescale 1ns/1ns
module tb;
   logic        ref_clk;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        debug_freeze;
   logic        sample_active;
   logic        convert_active;
   logic        conversion_done;
   logic        seq_busy;
   logic        frozen;
   logic        conv_clk_tick;
   logic [31:0] rd;
   logic        err;
   int          n_mismatch;
   int          num_checks;
   int          n;
   int          t;
   int          f;
   int          lens [8] = '{4, 6, 8, 10, 12, 16, 20, 24};

   adcsc_top adcsc_top_inst
   (
      .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .debug_freeze(debug_freeze), .sample_active(sample_active),
      .convert_active(convert_active), .conversion_done(conversion_done),
      .seq_busy(seq_busy), .frozen(frozen), .conv_clk_tick(conv_clk_tick)
   );

   // 25 MHz bus clock
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic conclude();
      if (n_mismatch == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic timed_out();
      n_mismatch++;
      $display("unexpected %0t wait ran out", $time);
      conclude();
   endtask

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected %0t flag %b want %b", $time, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge ref_clk);
         k++;
         if (k > 50) timed_out();
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic pick(input int k);
      case (k)
         0: return sample_active;
         1: return conv_clk_tick;
         2: return conversion_done;
         default: return convert_active;
      endcase
   endfunction

   // edges until the chosen output is seen high, bounded
   task automatic wait_for(input int k, output int c);
      c = 0;
      do
      begin
         @(posedge ref_clk);
         c++;
         if (c > 2000) timed_out();
      end
      while (pick(k) !== 1'b1);
   endtask

   // ticks counted while the chosen phase lasts; immune to tick alignment
   task automatic run_ticks(input int k, output int c);
      int e;
      c = 0;
      e = 0;
      while (pick(k) === 1'b1 && e < 3000)
      begin
         if (conv_clk_tick === 1'b1) c++;
         @(posedge ref_clk);
         e++;
      end
      if (e >= 3000) timed_out();
   endtask

   task automatic t_regs();
      apb(1'b0, adcsc_pkg::TIMING_OFFS, 32'h0);
      cmp_word(rd, 32'(adcsc_pkg::TIMING_RST));
      apb(1'b0, 8'h0c, 32'h0);
      cmp_bit(err, 1'b1);
      apb(1'b1, adcsc_pkg::TIMING_OFFS, 32'ha7);
      apb(1'b0, adcsc_pkg::TIMING_OFFS, 32'h0);
      cmp_word(rd, 32'ha7);
   endtask

   task automatic t_prescale();
      foreach (lens[i])
      begin
         apb(1'b1, adcsc_pkg::TIMING_OFFS, 32'(i * 4 + (i == 7 ? 3 : 0)));
         wait_for(1, n);
         wait_for(1, n);
         cmp_word(32'(n), 32'(2 * (i * 4 + (i == 7 ? 3 : 0) + 1)));
      end
   endtask

   // every sample code, then a timing write in mid-sequence
   task automatic t_sample();
      foreach (lens[i])
      begin
         apb(1'b1, adcsc_pkg::TIMING_OFFS, 32'(i * 32 + 1));
         apb(1'b1, adcsc_pkg::CTRL_OFFS, 32'h80);
         wait_for(0, n);
         run_ticks(0, t);
         cmp_word(32'(t), 32'(lens[i]));
         run_ticks(3, t);
         cmp_word(32'(t), 32'(adcsc_pkg::CONV_CYCLES));
         apb(1'b1, adcsc_pkg::TIMING_OFFS, 32'(i * 32 + 1));
         @(posedge ref_clk);
         cmp_bit(seq_busy, 1'b0);
      end
   endtask

   task automatic t_freeze_now();
      // shortest sample phase, so an unfrozen sequencer would leave it within 24 edges
      apb(1'b1, adcsc_pkg::TIMING_OFFS, 32'h01);
      apb(1'b1, adcsc_pkg::CTRL_OFFS, 32'h83);
      wait_for(0, n);
      debug_freeze <= 1'b1;
      repeat (24) @(posedge ref_clk);
      cmp_bit(sample_active, 1'b1);
      cmp_bit(frozen, 1'b1);
      debug_freeze <= 1'b0;
      wait_for(3, n);
      apb(1'b1, adcsc_pkg::TIMING_OFFS, 32'h21);
   endtask

   // finish the running conversion, then park in hold
   task automatic t_freeze_finish();
      apb(1'b1, adcsc_pkg::CTRL_OFFS, 32'h82);
      wait_for(0, n);
      debug_freeze <= 1'b1;
      wait_for(2, n);
      // 6 sample + 10 convert ticks at 4 bus cycles each, less the edge already past
      cmp_bit(n > 60 && n <= 64, 1'b1);
      repeat (20) @(posedge ref_clk);
      cmp_bit(sample_active | convert_active, 1'b0);
      apb(1'b0, adcsc_pkg::STATUS_OFFS, 32'h0);
      cmp_word(rd & 32'h0b, 32'h0b);
      debug_freeze <= 1'b0;
      wait_for(0, n);
      cmp_bit(n <= 8, 1'b1);
      apb(1'b1, adcsc_pkg::TIMING_OFFS, 32'h00);
   endtask

   // code 00 ignores the freeze request entirely
   task automatic t_freeze_off();
      debug_freeze <= 1'b1;
      apb(1'b1, adcsc_pkg::CTRL_OFFS, 32'h80);
      n = 0;
      t = 0;
      f = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
         if (conversion_done === 1'b1) t++;
         if (frozen !== 1'b0) f++;
      end
      while (seq_busy !== 1'b0 && n < 400);
      if (n >= 400) timed_out();
      cmp_word(32'(t), 32'(adcsc_pkg::SEQ_LEN));
      cmp_word(32'(f), 32'h0);
      debug_freeze <= 1'b0;
   endtask

   initial
   begin
      n_mismatch = 0;
      num_checks = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      debug_freeze = 1'b0;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs();
      t_prescale();
      t_sample();
      t_freeze_now();
      t_freeze_finish();
      t_freeze_off();
      conclude();
   end
endmodule // tb
